/* hdl/rsfe_pkg.sv */
/*
 * rsfe_pkg: constants and types shared by the boot strap and numeric
 * error logic.
 * assumes: nothing beyond a SystemVerilog compiler; no clocked logic here.
 */
package rsfe_pkg;

    // default width of the boot ROM address that passes through the block
    localparam int ADDR_WIDTH_DEF = 19;

    // address bits that may be inverted for boot-block flash recovery
    localparam int INV_BIT_8K  = 15;
    localparam int INV_BIT_16K = 16;
    localparam int INV_BIT_32K = 17;
    localparam int INV_BIT_64K = 18;

    // reset values of the captured straps and of the driven outputs
    localparam logic STRAP_RESET  = 1'h0;
    localparam logic IGNORE_RESET = 1'h0;
    localparam logic IRQ_RESET    = 1'h0;

    // the three boot straps, caught together as one word
    typedef struct packed {
        logic rom_type_strap;   // high: no address bit is inverted
        logic boot_strap_low;   // sampled on the address wrap gate pin
        logic boot_strap_high;  // sampled on the numeric error ignore pin
    } rsfe_strap_type;

    // decoded flash size that the straps select
    typedef enum logic [2:0] {
        RSFE_PASS  = 3'h0,
        RSFE_F8K   = 3'h1,
        RSFE_F16K  = 3'h2,
        RSFE_F32K  = 3'h3,
        RSFE_F64K  = 3'h4
    } rsfe_mode_type;

endpackage : rsfe_pkg

/* hdl/rsfe_strap_decode.sv */
/*
 * rsfe_strap_decode: turns the captured boot straps into an address
 * inversion mask and a flash size code.
 * assumes: the strap word is held stable by the caller; purely combinational.
 */
`timescale 1ns/100ps

module rsfe_strap_decode #(
    parameter int ADDR_WIDTH = rsfe_pkg::ADDR_WIDTH_DEF
) (
    input  wire rsfe_pkg::rsfe_strap_type i_straps,
    output rsfe_pkg::rsfe_mode_type       o_mode,
    output logic [ADDR_WIDTH-1:0]         o_mask
);
    import rsfe_pkg::*;

    // every mask bit that may be set must exist; refused at elaboration
    if (ADDR_WIDTH <= INV_BIT_64K) begin : g_width_check
        $error("ADDR_WIDTH too small for the strap inversion bits");
    end

    // the rom type strap overrides both size straps
    always_comb begin
        o_mode = RSFE_PASS;
        if (i_straps.rom_type_strap) begin
            o_mode = RSFE_PASS;
        end else begin
            case ({i_straps.boot_strap_low, i_straps.boot_strap_high})
                2'h3: o_mode = RSFE_F16K;
                2'h2: o_mode = RSFE_F32K;
                2'h1: o_mode = RSFE_F64K;
                2'h0: o_mode = RSFE_F8K;
                default: o_mode = RSFE_PASS;
            endcase
        end
    end

    // one hot mask; pass mode leaves every bit untouched
    always_comb begin
        o_mask = '0;
        case (o_mode)
            RSFE_F8K:  o_mask[INV_BIT_8K]  = 1'h1;
            RSFE_F16K: o_mask[INV_BIT_16K] = 1'h1;
            RSFE_F32K: o_mask[INV_BIT_32K] = 1'h1;
            RSFE_F64K: o_mask[INV_BIT_64K] = 1'h1;
            default:   o_mask = '0;
        endcase
    end

endmodule // rsfe_strap_decode

/* hdl/rsfe_top.sv */
/*
 * rsfe_top: boot ROM strap capture, ROM address inversion for boot-block
 * flash recovery, the numeric error ignore output and the coprocessor
 * interrupt request raised by the processor's floating point error.
 * assumes: I_RST is the power-up reset, all inputs are synchronous to
 * I_CLOCK, and the strap pull resistors settle before reset is released.
 */
// Behaviour
// - at power-up the straps are sampled: high on ignore, low on wrap gate, type on rom select.
// - rom type strap high inverts no ROM address bit, whatever the size straps hold.
// - type low, low strap high, high strap high inverts address bit 16 for a 16K by 8 flash.
// - all three straps low invert address bit 15 for an 8K by 8 flash.
// - type low, low strap high, high strap low inverts address bit 17 for a 32K by 8 flash.
// - type low, low strap low, high strap high inverts address bit 18 for a 64K by 8 flash.
// - after power-up the pin drives numeric error ignore; while high the processor skips errors.
// - the processor's floating point error raises coprocessor interrupt line 13.
`timescale 1ns/100ps

module rsfe_top #(
    parameter int ADDR_WIDTH = rsfe_pkg::ADDR_WIDTH_DEF
) (
    input  wire logic                  I_CLOCK,
    input  wire logic                  I_RST,
    // multiplexed numeric error ignore / high strap pin
    input  wire logic                  I_NUMERIC_ERROR_IGNORE,
    output logic                       O_NUMERIC_ERROR_IGNORE,
    output logic                       O_NUMERIC_ERROR_IGNORE_OE,
    // strap levels seen on the companion pins during power-up
    input  wire logic                  I_ADDRESS_WRAP_GATE,
    input  wire logic                  I_BOOT_ROM_SELECT,
    // request from the numeric error logic to assert ignore
    input  wire logic                  I_IGNORE_REQ,
    // ROM address from the cycle decoder and the address sent to the ROM
    input  wire logic [ADDR_WIDTH-1:0] I_ROM_ADDR,
    output logic [ADDR_WIDTH-1:0]      O_ROM_ADDR,
    // processor floating point error and the resulting interrupt request
    input  wire logic                  I_FPU_ERROR_IN,
    output logic                       O_COPROCESSOR_IRQ_LINE,
    // straps captured, the pin now works as an output
    output logic                       O_STRAPS_VALID,
    output rsfe_pkg::rsfe_mode_type    O_FLASH_MODE
);
    import rsfe_pkg::*;

    // the highest inverted bit must exist in the address; refused at elaboration
    if (ADDR_WIDTH <= INV_BIT_64K) begin : g_width_check
        $error("ADDR_WIDTH too small for the strap inversion bits");
    end

    logic                  captured;
    rsfe_strap_type        straps;
    rsfe_mode_type         mode;
    logic [ADDR_WIDTH-1:0] mask;
    rsfe_strap_type        next_straps;

    // strap word as it stands on the pins right now
    assign next_straps = '{rom_type_strap:  I_BOOT_ROM_SELECT,
                           boot_strap_low:  I_ADDRESS_WRAP_GATE,
                           boot_strap_high: I_NUMERIC_ERROR_IGNORE};

    // first edge after release marks the end of the strap window
    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            captured <= 1'h0;
        end else begin
            captured <= 1'h1;
        end
    end

    // straps are caught by a clocked edge, not by the reset itself, so the
    // flops see a constant while reset is high
    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            straps <= '{STRAP_RESET, STRAP_RESET, STRAP_RESET};
        end else if (!captured) begin
            straps <= next_straps;
        end
    end

    rsfe_strap_decode #(
        .ADDR_WIDTH (ADDR_WIDTH)
    ) u_decode (
        .i_straps (straps),
        .o_mode   (mode),
        .o_mask   (mask)
    );

    // address path: one register stage; mask is gated to zero until capture, which
    // is harmless because no ROM cycle runs in the first cycle after reset release
    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            O_ROM_ADDR <= '0;
        end else begin
            O_ROM_ADDR <= I_ROM_ADDR ^ (captured ? mask : '0);
        end
    end

    // pin is released while straps are sampled so the pull resistor wins,
    // then driven for the rest of operation
    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            O_NUMERIC_ERROR_IGNORE    <= IGNORE_RESET;
            O_NUMERIC_ERROR_IGNORE_OE <= 1'h0;
        end else if (captured) begin
            O_NUMERIC_ERROR_IGNORE    <= I_IGNORE_REQ;
            O_NUMERIC_ERROR_IGNORE_OE <= 1'h1;
        end
    end

    // floating point error is a level; the interrupt follows it a cycle late
    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            O_COPROCESSOR_IRQ_LINE <= IRQ_RESET;
        end else begin
            O_COPROCESSOR_IRQ_LINE <= I_FPU_ERROR_IN;
        end
    end

    // status seen by the rest of the chip
    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            O_STRAPS_VALID <= 1'h0;
            O_FLASH_MODE   <= RSFE_PASS;
        end else begin
            O_STRAPS_VALID <= captured;
            O_FLASH_MODE   <= mode;
        end
    end

    // checks

    default clocking cb @(posedge I_CLOCK);
    endclocking
    default disable iff (I_RST);

    sequence s_pin_released;
        !O_NUMERIC_ERROR_IGNORE_OE;
    endsequence

    sequence s_pin_driving;
        O_NUMERIC_ERROR_IGNORE_OE && (O_NUMERIC_ERROR_IGNORE == $past(I_IGNORE_REQ));
    endsequence

    sequence s_straps_taken;
        $rose(captured) && (straps == $past(next_straps));
    endsequence

    chk_strap_capture: assert property (
        $rose(captured) |-> s_straps_taken)
        else $error("straps differ from pin levels at capture");

    chk_strap_hold: assert property (
        captured && $past(captured) |-> $stable(straps) && $stable(mode))
        else $error("strap word changed after capture");

    chk_rom_pass: assert property (
        captured && straps.rom_type_strap |=> O_ROM_ADDR == $past(I_ROM_ADDR))
        else $error("address altered with rom type strap high");

    chk_invert_16k: assert property (
        captured && straps == 3'h3
        |=> (O_ROM_ADDR ^ $past(I_ROM_ADDR)) == (ADDR_WIDTH'(1) << INV_BIT_16K))
        else $error("bit 16 not the only inverted bit");

    chk_invert_8k: assert property (
        captured && straps == 3'h0
        |=> (O_ROM_ADDR ^ $past(I_ROM_ADDR)) == (ADDR_WIDTH'(1) << INV_BIT_8K))
        else $error("bit 15 not the only inverted bit");

    chk_invert_32k: assert property (
        captured && straps == 3'h2
        |=> (O_ROM_ADDR ^ $past(I_ROM_ADDR)) == (ADDR_WIDTH'(1) << INV_BIT_32K))
        else $error("bit 17 not the only inverted bit");

    chk_invert_64k: assert property (
        captured && straps == 3'h1
        |=> (O_ROM_ADDR ^ $past(I_ROM_ADDR)) == (ADDR_WIDTH'(1) << INV_BIT_64K))
        else $error("bit 18 not the only inverted bit");

    chk_pin_released: assert property (
        !captured |=> s_pin_released)
        else $error("pin driven during strap window");

    chk_ignore_drive: assert property (
        captured |=> s_pin_driving)
        else $error("ignore output does not follow request");

    chk_irq_follow: assert property (
        I_FPU_ERROR_IN ##1 I_FPU_ERROR_IN |-> O_COPROCESSOR_IRQ_LINE ##1 O_COPROCESSOR_IRQ_LINE)
        else $error("interrupt line not raised by fpu error");

    chk_irq_quiet: assert property (
        !I_FPU_ERROR_IN |=> !O_COPROCESSOR_IRQ_LINE)
        else $error("interrupt line high without fpu error");

    chk_irq_raise: assert property (
        $rose(I_FPU_ERROR_IN) |=> O_COPROCESSOR_IRQ_LINE)
        else $error("interrupt line not raised one cycle after fpu error");

    // no inversion and no ignore before the straps are caught, then status follows the capture
    chk_mask_gated: assert property (
        !captured |=> O_ROM_ADDR == $past(I_ROM_ADDR))
        else $error("address inverted before strap capture");

    chk_ignore_refused: assert property (
        !captured |=> !O_NUMERIC_ERROR_IGNORE)
        else $error("ignore asserted before strap capture");

    chk_status_follow: assert property (
        captured |=> O_STRAPS_VALID && (O_FLASH_MODE == $past(mode)))
        else $error("strap status does not follow capture");

    chk_mode_hold: assert property (
        O_STRAPS_VALID && $past(O_STRAPS_VALID) |-> $stable(O_FLASH_MODE))
        else $error("flash mode changed after capture");

    // the rom type strap leaves every bit alone and at most one bit flips
    chk_mask_pass: assert property (
        straps.rom_type_strap |-> mask == '0)
        else $error("mask not empty with rom type strap high");

    chk_mask_single: assert property (
        $onehot0(mask))
        else $error("more than one address bit inverted");

endmodule // rsfe_top

/* verification/rsfe_host_model.sv */
/*
 * rsfe_host_model: processor side of the numeric error pins, plus the
 * strap resistor on the shared ignore pin.
 * assumes: the bench sets the pull level and the error request.
 */
`timescale 1ns/100ps

module rsfe_host_model (
    input  wire logic i_pull_high,
    input  wire logic i_pin_out,
    input  wire logic i_pin_oe,
    input  wire logic i_error_req,
    output logic      o_pin,
    output logic      o_fpu_error
);
    // wire level: device wins while enabled, else the strap resistor sets it
    assign o_pin = i_pin_oe ? i_pin_out : i_pull_high;
    // processor error output, held for as long as the bench requests it
    assign o_fpu_error = i_error_req;
endmodule // rsfe_host_model

/* verification/test_rsfe_top.sv */
/*
 * test_rsfe_top: strap capture for all eight strap words, ROM address
 * inversion, ignore output and interrupt request, checked via a queue.
 * assumes: the design and the host model above; one 20 MHz clock.
 */
`timescale 1ns/100ps

module test_rsfe_top;
    import rsfe_pkg::*;
    typedef logic [ADDR_WIDTH_DEF+6:0] rsfe_obs_type;

    logic                      clock = 1'h0;
    logic                      rst = 1'h1;
    rsfe_strap_type            straps = '0;
    logic                      ign_req = 1'h1;
    logic                      err_req = 1'h0;
    logic [ADDR_WIDTH_DEF-1:0] rom_addr = '0;
    logic [ADDR_WIDTH_DEF-1:0] rom_out;
    logic                      pin, pin_out, pin_oe, fpu_err, irq, valid;
    rsfe_mode_type             mode;
    rsfe_obs_type              notes[$];
    int                        miscompares = 0;
    int                        tests_run = 0;

    rsfe_top i_dut (
        .I_CLOCK(clock), .I_RST(rst), .I_NUMERIC_ERROR_IGNORE(pin),
        .O_NUMERIC_ERROR_IGNORE(pin_out), .O_NUMERIC_ERROR_IGNORE_OE(pin_oe),
        .I_ADDRESS_WRAP_GATE(straps.boot_strap_low),
        .I_BOOT_ROM_SELECT(straps.rom_type_strap), .I_IGNORE_REQ(ign_req),
        .I_ROM_ADDR(rom_addr), .O_ROM_ADDR(rom_out), .I_FPU_ERROR_IN(fpu_err),
        .O_COPROCESSOR_IRQ_LINE(irq), .O_STRAPS_VALID(valid), .O_FLASH_MODE(mode)
    );

    rsfe_host_model i_host (
        .i_pull_high(straps.boot_strap_high), .i_pin_out(pin_out),
        .i_pin_oe(pin_oe), .i_error_req(err_req), .o_pin(pin),
        .o_fpu_error(fpu_err)
    );

    // free running clock, 50 ns period
    always #25 clock = ~clock;

    // flash size that a captured strap word selects
    function automatic rsfe_mode_type mode_of(input rsfe_strap_type c);
        if (c.rom_type_strap) return RSFE_PASS;
        case ({c.boot_strap_low, c.boot_strap_high})
            2'h3: return RSFE_F16K;
            2'h2: return RSFE_F32K;
            2'h1: return RSFE_F64K;
            default: return RSFE_F8K;
        endcase
    endfunction

    // one hot inversion mask for each flash size
    function automatic logic [ADDR_WIDTH_DEF-1:0] mask_of(input rsfe_mode_type m);
        case (m)
            RSFE_F8K:  return ADDR_WIDTH_DEF'(20'h0_8000);
            RSFE_F16K: return ADDR_WIDTH_DEF'(20'h1_0000);
            RSFE_F32K: return ADDR_WIDTH_DEF'(20'h2_0000);
            RSFE_F64K: return ADDR_WIDTH_DEF'(20'h4_0000);
            default:   return '0;
        endcase
    endfunction

    task automatic check(input rsfe_obs_type seen, input rsfe_obs_type want);
        tests_run++;
        if (seen !== want) begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic tally_and_finish();
        if (miscompares == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // one random cycle of traffic; the note is due one edge later
    task automatic drive(input rsfe_strap_type cap);
        rsfe_mode_type m;
        m = mode_of(cap);
        rom_addr = ADDR_WIDTH_DEF'($urandom);
        ign_req = 1'($urandom);
        err_req = 1'($urandom);
        notes.push_back({m, 1'h1, 1'h1, ign_req, err_req, rom_addr ^ mask_of(m)});
        @(negedge clock);
    endtask

    // results come every edge once notes exist; let the edge settle first
    always @(posedge clock) begin
        #1;
        if (notes.size() > 0)
            check({mode, valid, pin_oe, pin_out, irq, rom_out}, notes.pop_front());
    end

    // every strap word, each with its own power-up reset
    initial begin
        void'($urandom(75));
        for (int s = 0; s < 8; s++) begin
            rst = 1'h1;
            ign_req = 1'h1;
            straps = 3'(s);
            repeat (20) @(negedge clock);
            rst = 1'h0;
            // ignore request must be refused until the straps are caught
            @(posedge clock);
            #1;
            check(rsfe_obs_type'({valid, pin_oe, pin_out}), '0);
            @(negedge clock);
            for (int n = 0; n < 30; n++) begin
                // later pin levels must not disturb the latched choice
                if (n == 15) straps = ~straps;
                drive(3'(s));
            end
        end
        tally_and_finish();
    end

    // watchdog: about two and a half times the expected run
    initial begin
        #50000;
        miscompares++;
        tally_and_finish();
    end
endmodule // test_rsfe_top
